//--- verilog/erd_sequencer.v
// erd_sequencer.v - external rampdown sequencer with parameter range checks
// assumes one 20 MHz clock, supply/magnet current compare and zero flags from
// the regulation loop, operator keys as one-cycle pulses on the same clock
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "erd_consts.vh"
module erd_sequencer #(
    parameter SAMPLE_CYC = `ERD_SAMPLE_CYC,
    parameter SEC_CYC    = `ERD_SEC_CYC,
    parameter HOLD_CYC   = `ERD_HOLD_CYC
) (
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // register port
    input  wire [3:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    // contact input, high while shorted
    input  wire        rampdown_in,
    // regulation loop status
    input  wire        supply_eq_magnet,
    input  wire        current_zero,
    // operator
    input  wire        confirm_key,
    input  wire        op_ramp_req,
    input  wire        op_cool_start,
    // outputs
    output reg         at_target_indicator,
    output reg         persistent_indicator,
    output reg         superconducting_switch_heater,
    output reg         ramp_to_magnet,
    output reg         ramp_to_zero,
    output reg         op_ramp_grant,
    output reg         operator_locked,
    output reg         rampdown_complete,
    output reg         beep
);

localparam ST_IDLE  = 3'h0;
localparam ST_MATCH = 3'h1;
localparam ST_HOLD  = 3'h2;
localparam ST_HEAT  = 3'h3;
localparam ST_ZERO  = 3'h4;
localparam ST_DONE  = 3'h5;

// unsigned window check for the timing fields
function in_range12;
    input [11:0] v;
    input [11:0] lo;
    input [11:0] hi;
    begin
        in_range12 = (v >= lo) && (v <= hi);
    end
endfunction

// signed window check for the voltage and current limits
function in_range32s;
    input signed [31:0] v;
    input signed [31:0] lo;
    input signed [31:0] hi;
    begin
        in_range32s = (v >= lo) && (v <= hi);
    end
endfunction

// synchroniser
// the contact is asynchronous; only in_sync_r is read past this point
reg        in_meta_r;
reg        in_sync_r;
always @(posedge clock)
begin
    in_meta_r <= rampdown_in;
    in_sync_r <= in_meta_r;
end

// registers
reg         enable_r;
reg         persist_cfg_r;
reg  [11:0] heat_r;
reg  [11:0] cool_r;
reg  [31:0] vlim_r;
reg  [31:0] ilim_r;
reg  [31:0] vmax_r;
reg  [31:0] imin_r;
reg  [31:0] imax_r;

reg  [2:0]  state_r;
reg  [31:0] div_r;
reg  [31:0] tmr_r;
reg  [11:0] sec_r;
reg         cooling_r;
reg  [31:0] smp_r;
reg         trig_r;

// one-ms sample tick and one-second tick from free-running dividers
wire sample_tick = (smp_r == SAMPLE_CYC - 1);
wire sec_tick    = (div_r == SEC_CYC - 1);
wire busy        = (state_r != ST_IDLE);

// sampling: one look per ms, first shorted sample triggers
always @(posedge clock)
begin
    if (rst)
    begin
        smp_r  <= 32'h00000000;
        trig_r <= 1'b0;
    end
    else
    begin
        smp_r  <= sample_tick ? 32'h00000000 : smp_r + 32'h00000001;
        // a closure must span a tick to be seen; the far side holds it long enough
        trig_r <= sample_tick & in_sync_r & enable_r & ~busy;
    end
end

// register writes with range checking
always @(posedge clock)
begin
    if (rst)
    begin
        enable_r      <= 1'b0;
        persist_cfg_r <= 1'b0;
        heat_r        <= `ERD_HEAT_DEF;
        cool_r        <= `ERD_COOL_DEF;
        vlim_r        <= `ERD_VLIM_DEF;
        ilim_r        <= `ERD_ILIM_DEF;
        vmax_r        <= `ERD_VMAX_DEF;
        imin_r        <= `ERD_IMIN_DEF;
        imax_r        <= `ERD_IMAX_DEF;
        beep          <= 1'b0;
    end
    else
    begin
        beep <= 1'b0;
        // the magnet leaves persistent mode as the heating period ends
        if (state_r == ST_HEAT && sec_r == 12'h000 && sec_tick)
            persist_cfg_r <= 1'b0;
        if (wr)
        begin
            case (addr)
                `ERD_A_CTRL:
                begin
                    enable_r <= wdata[`ERD_C_EN];
                    // persistent bit ignores writes while a rampdown runs
                    if (!busy)
                        persist_cfg_r <= wdata[`ERD_C_PERS];
                end
                `ERD_A_HEAT:
                    if (in_range12(wdata[11:0], `ERD_HEAT_MIN, `ERD_HEAT_MAX) && wdata[31:12] == 20'h00000)
                        heat_r <= wdata[11:0];
                    else
                        beep <= 1'b1;
                `ERD_A_COOL:
                    if (in_range12(wdata[11:0], `ERD_COOL_MIN, `ERD_COOL_MAX) && wdata[31:12] == 20'h00000)
                        cool_r <= wdata[11:0];
                    else
                        beep <= 1'b1;
                `ERD_A_VLIM:
                    if (in_range32s(wdata, `ERD_VLIM_MIN, vmax_r))
                        vlim_r <= wdata;
                    else
                        beep <= 1'b1;
                `ERD_A_ILIM:
                    if (in_range32s(wdata, imin_r, imax_r))
                        ilim_r <= wdata;
                    else
                        beep <= 1'b1;
                `ERD_A_VMAX:
                    vmax_r <= wdata;
                `ERD_A_IMIN:
                    imin_r <= wdata;
                `ERD_A_IMAX:
                    imax_r <= wdata;
                default:
                    beep <= 1'b0;
            endcase
        end
    end
end

// sequencer
always @(posedge clock)
begin
    if (rst)
    begin
        state_r   <= ST_IDLE;
        div_r     <= 32'h00000000;
        tmr_r     <= 32'h00000000;
        sec_r     <= 12'h000;
        cooling_r <= 1'b0;
    end
    else
    begin
        div_r <= sec_tick ? 32'h00000000 : div_r + 32'h00000001;
        // operator-started switch cooling period
        if (op_cool_start && !busy && !cooling_r)
        begin
            cooling_r <= 1'b1;
            sec_r     <= cool_r;
        end
        else if (cooling_r && sec_tick)
        begin
            if (sec_r == 12'h000)
                cooling_r <= 1'b0;
            else
                sec_r <= sec_r - 12'h001;
        end
        case (state_r)
            ST_IDLE:
                if (trig_r)
                begin
                    // a trigger cuts a running cooling period short
                    cooling_r <= 1'b0;
                    state_r <= persist_cfg_r ? ST_MATCH : ST_ZERO;
                end
            ST_MATCH:
                if (supply_eq_magnet)
                begin
                    tmr_r   <= 32'h00000000;
                    state_r <= ST_HOLD;
                end
            // brief hold with the at-target indicator lit
            ST_HOLD:
                if (tmr_r == HOLD_CYC - 1)
                begin
                    sec_r   <= heat_r;
                    state_r <= ST_HEAT;
                end
                else
                    tmr_r <= tmr_r + 32'h00000001;
            // whole-second countdown, so heating may run up to one second longer than heat_r
            ST_HEAT:
                if (sec_tick)
                begin
                    if (sec_r == 12'h000)
                        state_r <= ST_ZERO;
                    else
                        sec_r <= sec_r - 12'h001;
                end
            // zeroing ends when the regulation loop reports zero current
            ST_ZERO:
                if (current_zero)
                    state_r <= ST_DONE;
            // confirm counts only once the synchronised contact is open
            ST_DONE:
                if (confirm_key && !in_sync_r)
                    state_r <= ST_IDLE;
            default:
                state_r <= ST_IDLE;
        endcase
    end
end

// registered outputs
always @(posedge clock)
begin
    if (rst)
    begin
        at_target_indicator           <= 1'b0;
        persistent_indicator          <= 1'b0;
        superconducting_switch_heater <= 1'b0;
        ramp_to_magnet                <= 1'b0;
        ramp_to_zero                  <= 1'b0;
        op_ramp_grant                 <= 1'b0;
        operator_locked               <= 1'b0;
        rampdown_complete             <= 1'b0;
        rdata                         <= 32'h00000000;
    end
    else
    begin
        at_target_indicator           <= (state_r == ST_HOLD) || (state_r == ST_HEAT);
        persistent_indicator          <= persist_cfg_r;
        superconducting_switch_heater <= (state_r == ST_HEAT);
        ramp_to_magnet                <= (state_r == ST_MATCH);
        ramp_to_zero                  <= (state_r == ST_ZERO);
        // grants are withheld through a rampdown and a cooling period
        op_ramp_grant                 <= op_ramp_req && !busy && !cooling_r;
        operator_locked               <= busy;
        rampdown_complete             <= (state_r == ST_DONE);
        // read data stand for one cycle only, zero otherwise
        if (rd)
        begin
            case (addr)
                `ERD_A_CTRL: rdata <= {30'h00000000, persist_cfg_r, enable_r};
                `ERD_A_HEAT: rdata <= {20'h00000, heat_r};
                `ERD_A_COOL: rdata <= {20'h00000, cool_r};
                `ERD_A_VLIM: rdata <= vlim_r;
                `ERD_A_ILIM: rdata <= ilim_r;
                `ERD_A_VMAX: rdata <= vmax_r;
                `ERD_A_IMIN: rdata <= imin_r;
                `ERD_A_IMAX: rdata <= imax_r;
                `ERD_A_STAT: rdata <= {26'h0000000, cooling_r, in_sync_r, 1'b0, state_r};
                default:     rdata <= 32'h00000000;
            endcase
        end
        else
            rdata <= 32'h00000000;
    end
end

endmodule // erd_sequencer

//--- verilog/erd_consts.vh
// erd_consts.vh - constants for the external rampdown sequencer
// assumes a 20 MHz clock; included by erd_sequencer.v
`ifndef ERD_CONSTS_VH
`define ERD_CONSTS_VH

`define ERD_CLK_HZ        20000000
`define ERD_MIN_CLOSE_MS  10
// one sample per ms, well inside the closure time
`define ERD_SAMPLE_CYC    (`ERD_CLK_HZ / 1000)
`define ERD_SEC_CYC       `ERD_CLK_HZ
`define ERD_HOLD_MS       500
`define ERD_HOLD_CYC      (`ERD_HOLD_MS * (`ERD_CLK_HZ / 1000))

`define ERD_HEAT_MIN      12'h005
`define ERD_HEAT_MAX      12'h078
`define ERD_HEAT_DEF      12'h014
`define ERD_COOL_MIN      12'h005
`define ERD_COOL_MAX      12'he10
`define ERD_COOL_DEF      12'h014
// voltage in mV, current in mA, signed 32 bit
`define ERD_VLIM_MIN      32'h00000001
`define ERD_VLIM_DEF      32'h000007d0
`define ERD_VMAX_DEF      32'h00001770
`define ERD_IMIN_DEF      32'hfffe17b8
`define ERD_IMAX_DEF      32'h0001e848
`define ERD_ILIM_DEF      32'h00013880

`define ERD_A_CTRL        4'h0
`define ERD_A_HEAT        4'h1
`define ERD_A_COOL        4'h2
`define ERD_A_VLIM        4'h3
`define ERD_A_ILIM        4'h4
`define ERD_A_VMAX        4'h5
`define ERD_A_IMIN        4'h6
`define ERD_A_IMAX        4'h7
`define ERD_A_STAT        4'h8

`define ERD_C_EN          0
`define ERD_C_PERS        1

`endif

//--- bench/erd_seq_properties.sv
// erd_seq_properties.sv - port checks for erd_sequencer
// assumes the simulation parameters of the bench, bound below
`timescale 1ns/1ps
module erd_seq_properties (
    // clock and reset
    input wire clock,
    input wire rst,
    // inputs
    input wire wr,
    input wire rampdown_in,
    input wire supply_eq_magnet,
    input wire current_zero,
    input wire confirm_key,
    input wire op_ramp_req,
    // outputs
    input wire beep,
    input wire at_target_indicator,
    input wire persistent_indicator,
    input wire superconducting_switch_heater,
    input wire ramp_to_magnet,
    input wire ramp_to_zero,
    input wire op_ramp_grant,
    input wire operator_locked,
    input wire rampdown_complete
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    heat_at_target_a: assert property (superconducting_switch_heater |-> at_target_indicator)
        else $error("heater on without at-target");
    heat_end_a: assert property ($fell(superconducting_switch_heater) |->
        ##[0:2] (ramp_to_zero && !persistent_indicator && !at_target_indicator))
        else $error("heating end did not start zeroing");
    busy_locked_a: assert property ((ramp_to_magnet || ramp_to_zero || rampdown_complete) |-> operator_locked)
        else $error("sequence running while unlocked");
    no_grant_a: assert property (operator_locked && $past(operator_locked) |-> !op_ramp_grant)
        else $error("ramp granted while locked");
    match_target_a: assert property (ramp_to_magnet && supply_eq_magnet |-> ##[1:3] at_target_indicator)
        else $error("match did not light at-target");
    zero_done_a: assert property (ramp_to_zero && current_zero |-> ##[1:3] rampdown_complete)
        else $error("zero current not reported");
    hold_confirm_a: assert property (rampdown_in[*8] ##0 (rampdown_complete && confirm_key)
        |-> ##2 rampdown_complete)
        else $error("confirm taken with input shorted");
    release_back_a: assert property ((!rampdown_in)[*8] ##0 (rampdown_complete && confirm_key)
        |-> ##[1:3] !operator_locked)
        else $error("confirm did not unlock");
    beep_cause_a: assert property (beep |-> $past(wr))
        else $error("beep without write");
    done_c: cover property (rampdown_complete && confirm_key);
    heat_c: cover property (superconducting_switch_heater);
    beep_c: cover property (beep);
endmodule // erd_seq_properties
bind erd_sequencer erd_seq_properties u_props (.*);

//--- bench/erd_contact_model.sv
// erd_contact_model.sv - outside relay contacts on the rampdown input
// assumes the bench raises close_req while the relay should be shut
`timescale 1ns/1ps
module erd_contact_model #(
    parameter MIN_CYC = 40
) (
    // clock
    input  wire clock,
    // control and contact
    input  wire close_req,
    output wire rampdown_in
);
    integer hold_r = 0;
    // a short request still keeps the contacts shut for the minimum time
    always @(posedge clock)
        hold_r <= close_req ? MIN_CYC : (hold_r > 0 ? hold_r - 1 : 0);
    assign rampdown_in = close_req || hold_r > 0;
endmodule // erd_contact_model

//--- bench/test_external_rampdown_sequencer.sv
// test_external_rampdown_sequencer.sv - self-checking bench for erd_sequencer
// assumes erd_consts.vh on the include path and the contact model
`timescale 1ns/1ps
`include "erd_consts.vh"
module test_external_rampdown_sequencer;
    reg         clock = 0, rst = 1, wr = 0, rd = 0, close_req = 0;
    reg  [3:0]  addr = 0;
    reg  [31:0] wdata = 0, d, ex [1:4];
    reg         supply_eq_magnet = 0, current_zero = 0, confirm_key = 0, op_ramp_req = 0, op_cool_start = 0;
    reg         okv;
    wire [31:0] rdata;
    wire        rampdown_in, at_target_indicator, persistent_indicator, superconducting_switch_heater;
    wire        ramp_to_magnet, ramp_to_zero, op_ramp_grant, operator_locked, rampdown_complete, beep;
    integer     bad_count = 0, total_checks = 0, i, v, a;

    erd_sequencer #(.SAMPLE_CYC(4), .SEC_CYC(8), .HOLD_CYC(4)) uut (.*);
    erd_contact_model u_contact (.clock(clock), .close_req(close_req), .rampdown_in(rampdown_in));

    initial forever #25 clock = ~clock;

    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task wreg(input [3:0] x, input [31:0] y);
        @(posedge clock);
        addr <= x; wdata <= y; wr <= 1;
        @(posedge clock);
        wr <= 0;
        #1;
    endtask

    task rreg(input [3:0] x);
        @(posedge clock);
        addr <= x; rd <= 1;
        @(posedge clock);
        rd <= 0;
        #1 d = rdata;
    endtask

    // 0 confirm, 1 ramp request, 2 cooling start
    task key(input integer s);
        @(posedge clock);
        confirm_key <= s == 0; op_ramp_req <= s == 1; op_cool_start <= s == 2;
        @(posedge clock);
        {confirm_key, op_ramp_req, op_cool_start} <= 0;
        #1;
    endtask

    function logic sg(input integer s);
        case (s)
            0: sg = ramp_to_magnet;
            1: sg = at_target_indicator;
            2: sg = superconducting_switch_heater;
            3: sg = ramp_to_zero;
            4: sg = rampdown_complete;
            5: sg = operator_locked;
            default: sg = rampdown_in;
        endcase
    endfunction

    task wt(input integer s, input logic y);
        integer n;
        #1;
        for (n = 0; n < 300 && sg(s) !== y; n++)
        begin
            @(posedge clock);
            #1;
        end
        chk("state wait", sg(s), y);
    endtask

    function integer bnd(input [3:0] x, input hi);
        case (x)
            `ERD_A_HEAT: bnd = hi ? 120 : 5;
            `ERD_A_COOL: bnd = hi ? 3600 : 5;
            `ERD_A_VLIM: bnd = hi ? 6000 : 1;
            default: bnd = hi ? 125000 : -125000;
        endcase
    endfunction

    task run_seq(input pers);
        wreg(`ERD_A_CTRL, {30'h0, pers, 1'b1});
        @(posedge clock) close_req <= 1;
        if (pers)
        begin
            wt(0, 1);
            @(posedge clock) supply_eq_magnet <= 1;
            wt(1, 1);
            wt(2, 1);
        end
        wt(3, 1);
        chk("at target", at_target_indicator, 0);
        chk("persistent", persistent_indicator, 0);
        rreg(`ERD_A_STAT);
        chk("status zeroing", d, 32'h14);
        key(1);
        chk("grant locked", op_ramp_grant, 0);
        @(posedge clock) current_zero <= 1;
        wt(4, 1);
        repeat (10) @(posedge clock);
        key(0);
        repeat (3) @(posedge clock);
        #1 chk("confirm shorted", rampdown_complete, 1);
        @(posedge clock) close_req <= 0;
        wt(6, 0);
        repeat (10) @(posedge clock);
        key(0);
        wt(5, 0);
        @(posedge clock) {current_zero, supply_eq_magnet} <= 0;
        $display("end of sequence test, persistent %0d", pers);
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        complete_run;
    end

    initial
    begin
        v = $urandom(20);
        ex[1] = 32'h14; ex[2] = 32'h14; ex[3] = 32'h7d0; ex[4] = 32'h13880;
        repeat (6) @(posedge clock);
        rst <= 0;
        for (a = 1; a <= 4; a++)
        begin
            rreg(a);
            chk("default", d, ex[a]);
        end
        rreg(4'hf);
        chk("unmapped", d, 0);
        $display("end of defaults test");
        for (i = 0; i < 48; i++)
        begin
            a = 1 + i % 4;
            if (i < 16)
                v = (i / 4) < 2 ? bnd(a, 0) - 1 + i / 4 : bnd(a, 1) - 2 + i / 4;
            else
                v = bnd(a, 0) - 10 + $urandom % (bnd(a, 1) - bnd(a, 0) + 20);
            okv = v >= bnd(a, 0) && v <= bnd(a, 1);
            wreg(a, v);
            chk("beep", beep, !okv);
            if (okv)
                ex[a] = v;
            rreg(a);
            chk("limit value", d, ex[a]);
        end
        $display("end of range test");
        rreg(`ERD_A_STAT);
        chk("status idle", d, 0);
        wreg(`ERD_A_VMAX, 3000);
        rreg(`ERD_A_VMAX);
        chk("vmax", d, 3000);
        wreg(`ERD_A_VLIM, 3001);
        chk("beep vmax", beep, 1);
        wreg(`ERD_A_VLIM, 3000);
        chk("beep vlim", beep, 0);
        rreg(`ERD_A_VLIM);
        chk("vlim at max", d, 3000);
        wreg(`ERD_A_IMIN, -1000);
        wreg(`ERD_A_IMAX, 1000);
        wreg(`ERD_A_ILIM, 1001);
        chk("beep imax", beep, 1);
        wreg(`ERD_A_ILIM, -1000);
        chk("beep imin", beep, 0);
        rreg(`ERD_A_ILIM);
        chk("ilim at min", d, -1000);
        $display("end of limit registers test");
        wreg(`ERD_A_HEAT, 5);
        wreg(`ERD_A_COOL, 5);
        key(1);
        chk("grant idle", op_ramp_grant, 1);
        key(2);
        rreg(`ERD_A_STAT);
        chk("status cooling", d, 32'h20);
        key(1);
        chk("grant cooling", op_ramp_grant, 0);
        repeat (70) @(posedge clock);
        key(1);
        chk("grant cooled", op_ramp_grant, 1);
        $display("end of cooling test");
        wreg(`ERD_A_CTRL, 0);
        @(posedge clock) close_req <= 1;
        repeat (20) @(posedge clock);
        #1 chk("disabled", operator_locked, 0);
        @(posedge clock) close_req <= 0;
        wt(6, 0);
        repeat (10) @(posedge clock);
        $display("end of disabled test");
        run_seq(0);
        run_seq(1);
        complete_run;
    end
endmodule // test_external_rampdown_sequencer
